// [include/ssp_pkg.sv]
// package of constants and types for the synchronous serial dce port
package ssp_pkg;

  // transmit clock phasing settings
  typedef enum logic [1:0]
  {
    SSP_PH_NORMAL = 2'b00,
    SSP_PH_INVERT = 2'b01,
    SSP_PH_AUTO = 2'b10
  } ssp_phase_t;

  // loop timing selection; remote setting is reserved and acts as off
  typedef enum logic [1:0]
  {
    SSP_LT_OFF = 2'b00,
    SSP_LT_ON = 2'b01,
    SSP_LT_REMOTE = 2'b10
  } ssp_lt_t;

  // register offsets
  localparam logic [3:0] SSP_ADDR_STATUS = 4'h0;
  localparam logic [3:0] SSP_ADDR_MASK = 4'h1;
  localparam logic [3:0] SSP_ADDR_STATE = 4'h2;
  localparam logic [3:0] SSP_ADDR_DIV = 4'h3;

  // event bit positions in status and mask
  localparam int SSP_EV_RR_RISE = 0;
  localparam int SSP_EV_RR_FALL = 1;
  localparam int SSP_EV_FAULT = 2;
  localparam int SSP_EV_TT_LOST = 3;
  localparam int SSP_EV_W = 4;

  // timing constants
  localparam int SSP_SYS_CLK_HZ = 25000000;
  localparam int SSP_DIV_W = 16;
  localparam logic [15:0] SSP_DIV_RESET = 16'h0004;
  localparam logic [7:0] SSP_TT_TIMEOUT = 8'h40;

endpackage

// [core/ssp_edge_det.sv]
// two-stage synchroniser with edge detection for one outside level
`timescale 1ns/1ps
module ssp_edge_det
  import ssp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed
  {
    logic meta;
    logic sync;
    logic last;
  } ssp_ed_state_t;

  ssp_ed_state_t st_ff;
  ssp_ed_state_t nxt_st;

  // first stage feeds only the second stage, so metastability stays contained
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign level = st_ff.sync;
  assign rise = st_ff.sync & ~st_ff.last;
  assign fall = ~st_ff.sync & st_ff.last;

endmodule

// [core/ssp_dce_port.sv]
// synchronous serial dce data port: clocks, data paths, loops, status and faults
`timescale 1ns/1ps

module ssp_dce_port
  import ssp_pkg::*;
#(
  parameter int DIV_W = SSP_DIV_W
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // static configuration
  input wire logic cfg_ext_clock,
  input wire logic [1:0] tx_clock_phase_select,
  input wire logic cfg_rx_clock_invert,
  input wire logic cfg_loopback,
  input wire logic [1:0] loop_timing_select,
  // terminal side lines
  input wire logic send_data,
  input wire logic terminal_timing,
  input wire logic request_to_send,
  output logic send_timing,
  output logic receive_data,
  output logic receive_timing,
  output logic clear_to_send,
  output logic data_mode,
  output logic receiver_ready,
  output logic mod_fault_oe,
  output logic demod_fault_oe,
  // modem side
  input wire logic demod_data,
  input wire logic demod_clock,
  input wire logic demod_carrier,
  input wire logic decoder_locked,
  input wire logic fault_common_in,
  input wire logic fault_mod_in,
  input wire logic fault_demod_in,
  output logic mod_data,
  output logic mod_data_valid,
  output logic fault_common,
  output logic fault_mod,
  output logic fault_demod,
  output logic loop_timing_led,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // ************************************************************
  // synchronisers for outside lines
  // ************************************************************
  logic tt_lvl;
  logic tt_rise;
  logic tt_fall;
  logic rc_lvl;
  logic rc_rise;
  logic sd_lvl;
  logic rd_lvl;
  logic rts_lvl;
  logic car_lvl;
  logic lock_lvl;

  ssp_edge_det u_tt
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(terminal_timing),
    .level(tt_lvl),
    .rise(tt_rise),
    .fall(tt_fall)
  );

  ssp_edge_det u_rc
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(demod_clock),
    .level(rc_lvl),
    .rise(rc_rise),
    .fall()
  );

  // plain two-flop synchronisers for data and status levels
  typedef struct packed
  {
    logic [4:0] meta;
    logic [4:0] sync;
  } ssp_sync_t;

  ssp_sync_t sy_ff;
  ssp_sync_t nxt_sy;

  always_comb
  begin
    nxt_sy.meta = {send_data, demod_data, request_to_send, demod_carrier, decoder_locked};
    nxt_sy.sync = sy_ff.meta;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sy_ff <= '0;
    else
      sy_ff <= nxt_sy;
  end

  assign sd_lvl = sy_ff.sync[4];
  assign rd_lvl = sy_ff.sync[3];
  assign rts_lvl = sy_ff.sync[2];
  assign car_lvl = sy_ff.sync[1];
  assign lock_lvl = sy_ff.sync[0];

  // ************************************************************
  // main state
  // ************************************************************
  typedef struct packed
  {
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] div_half;
    logic st_clk;
    logic st_rise;
    logic st_fall;
    logic sd_cap;
    logic sd_last;
    logic cap_valid;
    logic auto_pol;
    logic [7:0] tt_idle;
    logic tt_seen;
    logic send_timing;
    logic receive_data;
    logic receive_timing;
    logic clear_to_send;
    logic data_mode;
    logic receiver_ready;
    logic mod_fault_oe;
    logic demod_fault_oe;
    logic mod_data;
    logic mod_data_valid;
    logic fault_common;
    logic fault_mod;
    logic fault_demod;
    logic loop_timing_led;
    logic [SSP_EV_W-1:0] status;
    logic [SSP_EV_W-1:0] mask;
    logic [31:0] rdata;
    logic irq;
  } ssp_state_t;

  ssp_state_t st_ff;
  ssp_state_t nxt_st;

  // register address match, used by both the write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  logic loop_timing_on;
  logic sample_edge;
  logic sample_sel_rise;
  logic [SSP_EV_W-1:0] events;
  logic any_fault;
  logic rr_now;

  // remote loop timing setting is reserved and behaves as off
  assign loop_timing_on = (ssp_lt_t'(loop_timing_select) == SSP_LT_ON);

  // choose the sampling edge of the active transmit clock; data changes on one
  // edge so the opposite edge sits mid-bit, which keeps sampling off transitions
  always_comb
  begin
    case (ssp_phase_t'(tx_clock_phase_select))
      SSP_PH_NORMAL: sample_sel_rise = 1'b1;
      SSP_PH_INVERT: sample_sel_rise = 1'b0;
      SSP_PH_AUTO: sample_sel_rise = st_ff.auto_pol;
      default: sample_sel_rise = 1'b1;
    endcase
  end

  // external mode samples on the terminal clock, internal on our own
  assign sample_edge = cfg_ext_clock
    ? (sample_sel_rise ? tt_rise : tt_fall)
    : (sample_sel_rise ? st_ff.st_rise : st_ff.st_fall);

  assign rr_now = car_lvl & lock_lvl;
  assign any_fault = fault_common_in | fault_mod_in | fault_demod_in;

  always_comb
  begin
    events = '0;
    events[SSP_EV_RR_RISE] = rr_now & ~st_ff.receiver_ready;
    events[SSP_EV_RR_FALL] = ~rr_now & st_ff.receiver_ready;
    events[SSP_EV_FAULT] = any_fault & ~(st_ff.fault_common | st_ff.fault_mod | st_ff.fault_demod);
    events[SSP_EV_TT_LOST] = cfg_ext_clock & st_ff.tt_seen & (st_ff.tt_idle == SSP_TT_TIMEOUT);
  end

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.st_rise = 1'b0;
    nxt_st.st_fall = 1'b0;
    nxt_st.cap_valid = 1'b0;

    // internal send timing divider from the system clock
    if (st_ff.div_cnt >= st_ff.div_half)
    begin
      nxt_st.div_cnt = '0;
      nxt_st.st_clk = ~st_ff.st_clk;
      nxt_st.st_rise = ~st_ff.st_clk;
      nxt_st.st_fall = st_ff.st_clk;
    end
    else
      nxt_st.div_cnt = st_ff.div_cnt + 1'b1;

    // auto phasing: a clean clock is sampled on the edge opposite to launch,
    // so follow the clock level at the moment data is seen to change; judge the
    // change against the previous sample, since the captured bit lags until the
    // capture edge and would flip the choice on that very edge
    nxt_st.sd_last = sd_lvl;
    if (sd_lvl != st_ff.sd_last)
      nxt_st.auto_pol = cfg_ext_clock ? ~tt_lvl : ~st_ff.st_clk;

    // capture transmit data on the selected edge
    if (sample_edge)
    begin
      nxt_st.sd_cap = sd_lvl;
      nxt_st.cap_valid = 1'b1;
    end

    // terminal clock watchdog, saturating
    if (tt_rise | tt_fall)
    begin
      nxt_st.tt_idle = '0;
      nxt_st.tt_seen = 1'b1;
    end
    else if (st_ff.tt_idle != SSP_TT_TIMEOUT)
      nxt_st.tt_idle = st_ff.tt_idle + 8'h01;

    // send timing: recovered clock under loop timing, else internal clock
    nxt_st.send_timing = loop_timing_on ? rc_lvl : st_ff.st_clk;
    nxt_st.loop_timing_led = loop_timing_on;

    // receive path, or terminal loopback of send data and active clock
    if (cfg_loopback)
    begin
      nxt_st.receive_data = sd_lvl;
      nxt_st.receive_timing = cfg_ext_clock ? tt_lvl : st_ff.st_clk;
    end
    else
    begin
      nxt_st.receive_data = rd_lvl;
      // invert puts the falling edge mid-bit instead of the rising edge
      nxt_st.receive_timing = rc_lvl ^ cfg_rx_clock_invert;
    end

    // modulator input: received stream in modem-side loopback
    if (cfg_loopback)
    begin
      nxt_st.mod_data = rd_lvl;
      nxt_st.mod_data_valid = rc_rise;
    end
    else
    begin
      nxt_st.mod_data = st_ff.cap_valid ? st_ff.sd_cap : st_ff.mod_data;
      nxt_st.mod_data_valid = st_ff.cap_valid;
    end

    nxt_st.clear_to_send = rts_lvl;
    nxt_st.data_mode = 1'b1;
    nxt_st.receiver_ready = rr_now;

    // fault relays and open-collector lines; open circuit means fault
    nxt_st.fault_common = fault_common_in;
    nxt_st.fault_mod = fault_mod_in;
    nxt_st.fault_demod = fault_demod_in;
    nxt_st.mod_fault_oe = ~(fault_mod_in | fault_common_in);
    nxt_st.demod_fault_oe = ~(fault_demod_in | fault_common_in);

    // register writes; a new event wins over a clear in the same cycle
    nxt_st.status = st_ff.status;
    if (reg_wr & hit(reg_addr, SSP_ADDR_STATUS))
      nxt_st.status = st_ff.status & ~reg_wdata[SSP_EV_W-1:0];
    nxt_st.status = nxt_st.status | events;
    if (reg_wr & hit(reg_addr, SSP_ADDR_MASK))
      nxt_st.mask = reg_wdata[SSP_EV_W-1:0];
    if (reg_wr & hit(reg_addr, SSP_ADDR_DIV))
      nxt_st.div_half = reg_wdata[DIV_W-1:0];

    // register reads, data valid the cycle after the strobe
    nxt_st.rdata = '0;
    if (reg_rd)
    begin
      if (hit(reg_addr, SSP_ADDR_STATUS))
        nxt_st.rdata = 32'(st_ff.status);
      else if (hit(reg_addr, SSP_ADDR_MASK))
        nxt_st.rdata = 32'(st_ff.mask);
      else if (hit(reg_addr, SSP_ADDR_STATE))
        nxt_st.rdata = 32'({st_ff.loop_timing_led, st_ff.fault_demod, st_ff.fault_mod,
                            st_ff.fault_common, st_ff.receiver_ready, st_ff.clear_to_send,
                            st_ff.auto_pol});
      else if (hit(reg_addr, SSP_ADDR_DIV))
        nxt_st.rdata = 32'(st_ff.div_half);
    end

    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.div_half <= DIV_W'(SSP_DIV_RESET);
      st_ff.auto_pol <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign send_timing = st_ff.send_timing;
  assign receive_data = st_ff.receive_data;
  assign receive_timing = st_ff.receive_timing;
  assign clear_to_send = st_ff.clear_to_send;
  assign data_mode = st_ff.data_mode;
  assign receiver_ready = st_ff.receiver_ready;
  assign mod_fault_oe = st_ff.mod_fault_oe;
  assign demod_fault_oe = st_ff.demod_fault_oe;
  assign mod_data = st_ff.mod_data;
  assign mod_data_valid = st_ff.mod_data_valid;
  assign fault_common = st_ff.fault_common;
  assign fault_mod = st_ff.fault_mod;
  assign fault_demod = st_ff.fault_demod;
  assign loop_timing_led = st_ff.loop_timing_led;
  assign reg_rdata = st_ff.rdata;
  assign irq = st_ff.irq;

endmodule

// [dv/ssp_dce_port_properties.sv]
// checker of port timing for the dce port, bound to the top module
`timescale 1ns/1ps
module ssp_dce_port_properties
  import ssp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cfg_loopback,
  input wire logic cfg_rx_clock_invert,
  input wire logic [1:0] loop_timing_select,
  input wire logic send_data,
  input wire logic request_to_send,
  input wire logic demod_data,
  input wire logic demod_clock,
  input wire logic demod_carrier,
  input wire logic decoder_locked,
  input wire logic fault_common_in,
  input wire logic fault_mod_in,
  input wire logic fault_demod_in,
  input wire logic send_timing,
  input wire logic receive_data,
  input wire logic receive_timing,
  input wire logic clear_to_send,
  input wire logic data_mode,
  input wire logic receiver_ready,
  input wire logic mod_fault_oe,
  input wire logic demod_fault_oe,
  input wire logic fault_common,
  input wire logic loop_timing_led
);
  // ****************
  // port properties
  // ****************
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // synchroniser depth is three cycles, so five steady cycles leave margin
  cts_follow_a: assert property ($stable(request_to_send)[*5] |->
    clear_to_send == request_to_send) else $error("cts not following rts");
  data_mode_a: assert property ($past(reset_n) |-> data_mode)
    else $error("data mode low");
  rr_on_a: assert property ((demod_carrier && decoder_locked)[*5] |->
    receiver_ready) else $error("receiver ready missing");
  rr_off_a: assert property ((!decoder_locked)[*5] |-> !receiver_ready)
    else $error("receiver ready without lock");
  mod_oe_a: assert property ((fault_mod_in || fault_common_in)[*2] |->
    !mod_fault_oe) else $error("mod fault line not open");
  demod_oe_a: assert property ((fault_demod_in || fault_common_in)[*2] |->
    !demod_fault_oe) else $error("demod fault line not open");
  relay_a: assert property (fault_common_in[*2] |-> fault_common)
    else $error("common relay not driven");
  led_on_a: assert property ((loop_timing_select == SSP_LT_ON)[*2] |->
    loop_timing_led) else $error("loop timing light off");
  led_off_a: assert property ((loop_timing_select != SSP_LT_ON)[*2] |->
    !loop_timing_led) else $error("loop timing light on");
  rx_clock_a: assert property ((!cfg_loopback && $stable(cfg_rx_clock_invert)
    && $stable(demod_clock))[*5] |-> receive_timing == (demod_clock ^ cfg_rx_clock_invert))
    else $error("rt wrong");
  rx_data_a: assert property ((!cfg_loopback && $stable(demod_data))[*5] |->
    receive_data == demod_data) else $error("rd wrong");
  loop_data_a: assert property ((cfg_loopback && $stable(send_data))[*5] |->
    receive_data == send_data) else $error("sd not looped to rd");
  lt_clock_a: assert property (((loop_timing_select == SSP_LT_ON)
    && $stable(demod_clock))[*5] |-> send_timing == demod_clock) else $error("st wrong");
endmodule

bind ssp_dce_port ssp_dce_port_properties chk (.sys_clk, .reset_n, .cfg_loopback,
  .cfg_rx_clock_invert, .loop_timing_select, .send_data, .request_to_send, .demod_data,
  .demod_clock, .demod_carrier, .decoder_locked, .fault_common_in, .fault_mod_in,
  .fault_demod_in, .send_timing, .receive_data, .receive_timing, .clear_to_send,
  .data_mode, .receiver_ready, .mod_fault_oe, .demod_fault_oe, .fault_common,
  .loop_timing_led);

// [dv/ssp_dte_model.sv]
// terminal and demodulator model that feeds the port's serial lines
`timescale 1ns/1ps
module ssp_dte_model
(
  input wire logic send_timing,
  output logic send_data,
  output logic terminal_timing,
  output logic demod_data,
  output logic demod_clock
);
  // ****************
  // line drivers
  // ****************
  // clocks stand still between frames
  initial
  begin
    send_data = 1'b0;
    terminal_timing = 1'b0;
    demod_data = 1'b0;
    demod_clock = 1'b0;
  end
  // one byte msb first; odd offset keeps the link clock off the system edges
  task automatic tx_byte(input logic [7:0] b, input logic ext, input logic inv);
    // lead-in change at the idle clock level, so auto phasing learns before bit one
    terminal_timing <= inv;
    send_data <= !b[7];
    #413;
    for (int i = 7; i >= 0; i--)
    begin
      if (ext)
      begin
        send_data = b[i];
        #160 terminal_timing = !inv;
        #160 terminal_timing = inv;
      end
      else
      begin
        @(negedge send_timing);
        send_data <= b[i];
      end
    end
    if (!ext)
      @(negedge send_timing);
    send_data <= !send_data;
  endtask
  // received bits change while the recovered clock is low
  task automatic rx_byte(input logic [7:0] b);
    #13;
    for (int i = 7; i >= 0; i--)
    begin
      demod_data = b[i];
      #160 demod_clock = 1'b1;
      #160 demod_clock = 1'b0;
    end
    demod_data = !demod_data;
  endtask
endmodule

// [dv/ssp_dce_port_test.sv]
// self-checking bench of the dce port
`timescale 1ns/1ps
module ssp_dce_port_test;
  import ssp_pkg::*;
  logic sys_clk, reset_n, cfg_ext_clock, cfg_rx_clock_invert, cfg_loopback;
  logic [1:0] tx_clock_phase_select, loop_timing_select;
  logic send_data, terminal_timing, request_to_send, send_timing, receive_data;
  logic receive_timing, clear_to_send, data_mode, receiver_ready, mod_fault_oe;
  logic demod_fault_oe, demod_data, demod_clock, demod_carrier, decoder_locked;
  logic fault_common_in, fault_mod_in, fault_demod_in, mod_data, mod_data_valid;
  logic fault_common, fault_mod, fault_demod, loop_timing_led, reg_wr, reg_rd, irq;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [7:0] cap, rx_pos, rx_neg;
  int fail_count, comparisons, cyc, t0, st_rises;
  // ****************
  // structure
  // ****************
  ssp_dce_port dut (.sys_clk, .reset_n, .cfg_ext_clock, .tx_clock_phase_select,
    .cfg_rx_clock_invert, .cfg_loopback, .loop_timing_select, .send_data,
    .terminal_timing, .request_to_send, .send_timing, .receive_data, .receive_timing,
    .clear_to_send, .data_mode, .receiver_ready, .mod_fault_oe, .demod_fault_oe,
    .demod_data, .demod_clock, .demod_carrier, .decoder_locked, .fault_common_in,
    .fault_mod_in, .fault_demod_in, .mod_data, .mod_data_valid, .fault_common,
    .fault_mod, .fault_demod, .loop_timing_led, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq);
  ssp_dte_model dte (.send_timing, .send_data, .terminal_timing, .demod_data,
    .demod_clock);
  // clock, and a cycle count that bounds the run
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // modulator input gathered msb first
  always @(posedge sys_clk)
    if (mod_data_valid === 1'b1)
      cap <= {cap[6:0], mod_data};
  // receive data taken on each receive clock edge; send clock rises counted
  always @(posedge receive_timing)
    rx_pos <= {rx_pos[6:0], receive_data};
  always @(negedge receive_timing)
    rx_neg <= {rx_neg[6:0], receive_data};
  always @(posedge send_timing)
    st_rises <= st_rises + 1;
  // ****************
  // tasks
  // ****************
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rd(SSP_ADDR_DIV);
    cmp("div reset", 32'h4, d);
    wr(SSP_ADDR_DIV, 32'h7);
    rd(SSP_ADDR_DIV);
    cmp("div", 32'h7, d);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf);
    cmp("unmapped", 32'h0, d);
    @(posedge send_timing);
    t0 = cyc;
    @(posedge send_timing);
    cmp("st period", 32'd16, cyc - t0);
  endtask
  // every phasing setting with the matching terminal clock edge
  task automatic t_send();
    logic [1:0] ph [4] = '{SSP_PH_NORMAL, SSP_PH_INVERT, SSP_PH_AUTO, SSP_PH_AUTO};
    cfg_ext_clock <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      tx_clock_phase_select <= ph[i];
      settle();
      dte.tx_byte(8'ha5 ^ 8'(i), 1'b1, i[0]);
      settle();
      cmp("ext capture", 32'(8'ha5 ^ 8'(i)), 32'(cap));
    end
    cfg_ext_clock <= 1'b0;
    tx_clock_phase_select <= SSP_PH_NORMAL;
    settle();
    dte.tx_byte(8'h3c, 1'b0, 1'b0);
    repeat (4) @(negedge sys_clk);
    cmp("int capture", 32'h3c, 32'(cap));
  endtask
  task automatic t_loops();
    for (int i = 0; i < 2; i++)
    begin
      cfg_rx_clock_invert <= i[0];
      dte.rx_byte(8'h96);
      settle();
      cmp("rt idle", 32'(i[0]), 32'(receive_timing));
      cmp("rt mid-bit edge", 32'h96, 32'(i[0] ? rx_neg : rx_pos));
    end
    cfg_rx_clock_invert <= 1'b0;
    cfg_loopback <= 1'b1;
    cfg_ext_clock <= 1'b1;
    dte.rx_byte(8'h5c);
    settle();
    cmp("loop to mod", 32'h5c, 32'(cap));
    dte.tx_byte(8'h81, 1'b1, 1'b0);
    cmp("loop to rd", 32'h81, 32'(rx_pos));
    cfg_loopback <= 1'b0;
    loop_timing_select <= SSP_LT_ON;
    settle();
    cmp("led on", 32'h1, 32'(loop_timing_led));
    t0 = st_rises;
    dte.rx_byte(8'h0f);
    cmp("st from rt", 32'd8, st_rises - t0);
    loop_timing_select <= SSP_LT_REMOTE;
    settle();
    cmp("led remote", 32'h0, 32'(loop_timing_led));
    loop_timing_select <= SSP_LT_OFF;
  endtask
  task automatic t_status();
    cmp("dm", 32'h1, 32'(data_mode));
    request_to_send <= 1'b1;
    settle();
    cmp("cts", 32'h1, 32'(clear_to_send));
    demod_carrier <= 1'b1;
    decoder_locked <= 1'b1;
    settle();
    cmp("rr", 32'h1, 32'(receiver_ready));
    decoder_locked <= 1'b0;
    settle();
    cmp("rr unlock", 32'h0, 32'(receiver_ready));
    rd(SSP_ADDR_STATUS);
    cmp("status events", 32'hb, d);
    wr(SSP_ADDR_MASK, 32'h1 << SSP_EV_FAULT);
    wr(SSP_ADDR_STATUS, 32'hf);
    fault_mod_in <= 1'b1;
    settle();
    cmp("mod oe", 32'h1, {mod_fault_oe, demod_fault_oe});
    cmp("mod relay", 32'h1, 32'(fault_mod));
    cmp("irq", 32'h1, 32'(irq));
    fault_mod_in <= 1'b0;
    fault_common_in <= 1'b1;
    fault_demod_in <= 1'b1;
    settle();
    cmp("common oe", 32'h0, {mod_fault_oe, demod_fault_oe});
    cmp("relays", 32'h5, {fault_common, fault_mod, fault_demod});
    fault_common_in <= 1'b0;
    fault_demod_in <= 1'b0;
    wr(SSP_ADDR_MASK, 32'h0);
    cmp("irq masked", 32'h0, 32'(irq));
    wr(SSP_ADDR_MASK, 32'h1 << SSP_EV_FAULT);
    wr(SSP_ADDR_STATUS, 32'h1 << SSP_EV_FAULT);
    rd(SSP_ADDR_STATUS);
    cmp("status clear", 32'h0, 32'(d[SSP_EV_FAULT]));
    cmp("irq cleared", 32'h0, 32'(irq));
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {reset_n, cfg_ext_clock, cfg_rx_clock_invert, cfg_loopback, request_to_send} = '0;
    {demod_carrier, decoder_locked, fault_common_in, fault_mod_in, fault_demod_in} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, cap} = '0;
    tx_clock_phase_select = SSP_PH_NORMAL;
    loop_timing_select = SSP_LT_OFF;
    {fail_count, comparisons, cyc} = '0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_send();
    t_loops();
    t_status();
    stop_test();
  end
endmodule
